// *** verilog/irq_mask_pkg.sv ***
// Constants for the interrupt mask and status unit
package irq_mask_pkg;
    // ****************************************************
    // Write value field positions
    // ****************************************************
    localparam int WR_LOW_MASK_BIT  = 0;
    localparam int WR_MID_MASK_BIT  = 1;
    localparam int WR_TOP_MASK_BIT  = 2;
    localparam int WR_QUALIFIER_BIT = 3;
    localparam int WR_CLR_TOP_BIT   = 4;
    // ****************************************************
    // Read value field positions
    // ****************************************************
    localparam int RD_MASK_LSB      = 0;
    localparam int RD_IE_BIT        = 3;
    localparam int RD_PEND_LSB      = 4;
    localparam int RD_SPARE_BIT     = 7;
    // ****************************************************
    // Widths and reset values
    // ****************************************************
    localparam int        DATA_W     = 8;
    localparam int        NUM_IRQ    = 3;
    localparam logic [2:0] MASK_RST  = 3'h7;
    localparam logic [7:0] READ_RST  = 8'h07;
endpackage

// *** verilog/irq_input_sync.sv ***
// Two-stage synchroniser for the restart request inputs and edge latch for the top input
module irq_input_sync (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       srst,
    // Raw request pins: top, mid, low
    input  wire logic [2:0] irq_pin,
    // Edge latch clear for the top input
    input  wire logic       clear_top_edge_latch,
    // Synchronised levels and latched top edge
    output logic      [2:0] irq_level,
    output logic            top_edge_latched
);
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic       top_prev_r;
    logic       top_edge_r;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
        end else begin
            meta_r <= irq_pin;
            sync_r <= meta_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            top_prev_r <= 1'h0;
            top_edge_r <= 1'h0;
        end else begin
            top_prev_r <= sync_r[2];
            // New rising edge beats a clear in the same cycle
            if (sync_r[2] && !top_prev_r)
                top_edge_r <= 1'h1;
            else if (clear_top_edge_latch)
                top_edge_r <= 1'h0;
        end
    end

    assign irq_level        = sync_r;
    assign top_edge_latched = top_edge_r;
endmodule

// *** verilog/interrupt_mask_status_unit.sv ***
// Interrupt mask write and status read logic of the processor
// Notes on behaviour
// - Mask-write instruction takes the accumulator value as its source.
// - Written bit 4 set clears the top restart input edge latch.
// - Mask bits load only when written bit 3 is one.
// - Qualified write sets top mask from bit 2; one masks.
// - Qualified write sets middle mask from bit 1; one masks.
// - Qualified write sets low mask from bit 0; one masks.
// - Status read returns pending top, mid, low in bits 6, 5, 4.
// - Status read bit 3 shows the global interrupt enable flag.
// - Status read bits 2 to 0 return top, mid, low masks.
module interrupt_mask_status_unit #(
    parameter int DATA_W  = irq_mask_pkg::DATA_W,
    parameter int NUM_IRQ = irq_mask_pkg::NUM_IRQ
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       srst,
    // Instruction strobes from the core
    input  wire logic       mask_write_instr,
    input  wire logic       status_read_instr,
    input  wire logic [7:0] accumulator,
    input  wire logic       global_irq_enable_flag,
    // Restart request pins
    input  wire logic       top_restart_irq,
    input  wire logic       mid_restart_irq,
    input  wire logic       low_restart_irq,
    // Results
    output logic      [7:0] status_read_value,
    output logic      [2:0] irq_mask,
    output logic      [2:0] irq_pending
);
    logic [2:0] mask_r;
    logic [2:0] mask_nxt;
    logic [7:0] rd_r;
    logic [7:0] rd_nxt;
    logic [2:0] pend_r;
    logic [2:0] level;
    logic       top_edge;
    logic       clear_top_edge_latch;
    logic       mask_load_qualifier;
    logic       wr_top_mask;
    logic       wr_mid_mask;
    logic       wr_low_mask;
    logic       ie_sync1_r;
    logic       ie_sync2_r;

    // ****************************************************
    // Parameter checks
    // ****************************************************
    // Field positions assume one byte and three request inputs
    if (DATA_W != 8) begin : g_bad_data_w
        $error("interrupt mask unit needs DATA_W of 8");
    end
    if (NUM_IRQ != 3) begin : g_bad_num_irq
        $error("interrupt mask unit needs NUM_IRQ of 3");
    end
    if (irq_mask_pkg::RD_PEND_LSB + NUM_IRQ > DATA_W) begin : g_bad_pend
        $error("pending field does not fit the status byte");
    end
    if (irq_mask_pkg::RD_SPARE_BIT != DATA_W - 1) begin : g_bad_spare
        $error("spare bit must be the top status bit");
    end
    if (irq_mask_pkg::WR_CLR_TOP_BIT >= DATA_W) begin : g_bad_clr
        $error("clear bit lies outside the written byte");
    end
    if (irq_mask_pkg::WR_QUALIFIER_BIT >= DATA_W) begin : g_bad_qual
        $error("qualifier bit lies outside the written byte");
    end

    // ****************************************************
    // Field helpers
    // ****************************************************
    // Bit of the written value at a field position
    function automatic logic wr_bit(
        input logic [7:0] value,
        input int         pos
    );
        return value[pos];
    endfunction

    // New mask: the fields replace it only on a qualified write
    function automatic logic [2:0] mask_merge(
        input logic [2:0] old_mask,
        input logic       load,
        input logic       top,
        input logic       mid,
        input logic       low
    );
        logic [2:0] result;
        result = old_mask;
        if (load) begin
            result[2] = top;
            result[1] = mid;
            result[0] = low;
        end
        return result;
    endfunction

    // Pending word: top from the edge latch, mid and low from levels
    function automatic logic [2:0] pend_word(
        input logic       top_latch,
        input logic [2:0] lvl
    );
        return {top_latch, lvl[1], lvl[0]};
    endfunction

    // Status byte: spare, pending, enable flag, masks
    function automatic logic [7:0] pack_status(
        input logic [2:0] pend,
        input logic       ie,
        input logic [2:0] mask
    );
        logic [7:0] word;
        word = 8'h00;
        word[irq_mask_pkg::RD_SPARE_BIT] = 1'h0;
        word[irq_mask_pkg::RD_PEND_LSB +: 3] = pend;
        word[irq_mask_pkg::RD_IE_BIT] = ie;
        word[irq_mask_pkg::RD_MASK_LSB +: 3] = mask;
        return word;
    endfunction

    // ****************************************************
    // Request inputs
    // ****************************************************
    // Pin to pending: three edges for mid and low, four for top
    // A new top edge in the clear cycle keeps the latch set
    // clear latch request
    assign clear_top_edge_latch = mask_write_instr &&
        wr_bit(accumulator, irq_mask_pkg::WR_CLR_TOP_BIT);

    irq_input_sync u_sync (
        .sys_clk              (sys_clk),
        .srst                 (srst),
        .irq_pin              ({top_restart_irq, mid_restart_irq,
                                low_restart_irq}),
        .clear_top_edge_latch (clear_top_edge_latch),
        .irq_level            (level),
        .top_edge_latched     (top_edge)
    );

    // ****************************************************
    // Enable flag synchroniser
    // ****************************************************
    // Flag treated as asynchronous: two stages
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ie_sync1_r <= 1'h0;
            ie_sync2_r <= 1'h0;
        end else begin
            ie_sync1_r <= global_irq_enable_flag;
            ie_sync2_r <= ie_sync1_r;
        end
    end

    // ****************************************************
    // Write decode
    // ****************************************************
    // accumulator is the write source
    assign mask_load_qualifier = mask_write_instr &&
        wr_bit(accumulator, irq_mask_pkg::WR_QUALIFIER_BIT);
    assign wr_top_mask = wr_bit(accumulator, irq_mask_pkg::WR_TOP_MASK_BIT);
    assign wr_mid_mask = wr_bit(accumulator, irq_mask_pkg::WR_MID_MASK_BIT);
    assign wr_low_mask = wr_bit(accumulator, irq_mask_pkg::WR_LOW_MASK_BIT);

    // ****************************************************
    // Mask register
    // ****************************************************
    always_comb begin
        mask_nxt = mask_merge(mask_r, mask_load_qualifier, wr_top_mask,
                              wr_mid_mask, wr_low_mask);
    end

    always_ff @(posedge sys_clk) begin
        if (srst)
            mask_r <= irq_mask_pkg::MASK_RST;
        else
            mask_r <= mask_nxt;
    end

    // ****************************************************
    // Pending flags
    // ****************************************************
    always_ff @(posedge sys_clk) begin
        if (srst)
            pend_r <= 3'h0;
        else
            pend_r <= pend_word(top_edge, level);
    end

    // ****************************************************
    // Status read
    // ****************************************************
    // A read just after a clear still shows the old latch
    always_comb begin
        rd_nxt = rd_r;
        if (status_read_instr)
            rd_nxt = pack_status(pend_r, ie_sync2_r, mask_r);
    end

    always_ff @(posedge sys_clk) begin
        if (srst)
            rd_r <= irq_mask_pkg::READ_RST;
        else
            rd_r <= rd_nxt;
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    // Each output is a register
    assign status_read_value = rd_r;
    assign irq_mask          = mask_r;
    assign irq_pending       = pend_r;
endmodule

// *** verif/irq_mask_properties.sv ***
// Checker for the interrupt mask and status unit
module irq_mask_properties (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       srst,
    // Inputs
    input wire logic       mask_write_instr,
    input wire logic       status_read_instr,
    input wire logic       global_irq_enable_flag,
    input wire logic       top_restart_irq,
    input wire logic       mid_restart_irq,
    input wire logic       low_restart_irq,
    input wire logic [7:0] accumulator,
    // Outputs
    input wire logic [7:0] status_read_value,
    input wire logic [2:0] irq_mask,
    input wire logic [2:0] irq_pending
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    AST_HOLD: assert property (
        mask_write_instr && !accumulator[3] |=> $stable(irq_mask))
        else $error("mask moved");
    AST_TOP: assert property (
        mask_write_instr && accumulator[3]
        |=> irq_mask[2] == $past(accumulator[2]))
        else $error("top mask");
    AST_MID: assert property (
        mask_write_instr && accumulator[3]
        |=> irq_mask[1] == $past(accumulator[1]))
        else $error("mid mask");
    AST_LOW: assert property (
        mask_write_instr && accumulator[3]
        |=> irq_mask[0] == $past(accumulator[0]))
        else $error("low mask");
    AST_RD_MASK: assert property (
        status_read_instr |=> status_read_value[2:0] == $past(irq_mask))
        else $error("read mask");
    AST_RD_PEND: assert property (
        status_read_instr
        |=> status_read_value[7:4] == {1'b0, $past(irq_pending)})
        else $error("read pending");
    AST_RD_IE: assert property (
        status_read_instr
        |=> status_read_value[3] == $past(global_irq_enable_flag, 3))
        else $error("read enable");
    AST_CLR: assert property (
        !top_restart_irq [*4] ##0 (mask_write_instr && accumulator[4])
        |-> ##2 !irq_pending[2])
        else $error("top latch kept");
    cover property (mask_write_instr && accumulator[3]);
    cover property (status_read_instr && irq_pending[2]);
    cover property (mask_write_instr && accumulator[4] && irq_pending[2]);
endmodule
bind interrupt_mask_status_unit irq_mask_properties i_chk (
    .sys_clk                (sys_clk),
    .srst                   (srst),
    .mask_write_instr       (mask_write_instr),
    .status_read_instr      (status_read_instr),
    .global_irq_enable_flag (global_irq_enable_flag),
    .top_restart_irq        (top_restart_irq),
    .mid_restart_irq        (mid_restart_irq),
    .low_restart_irq        (low_restart_irq),
    .accumulator            (accumulator),
    .status_read_value      (status_read_value),
    .irq_mask               (irq_mask),
    .irq_pending            (irq_pending)
);

// *** verif/irq_line_model.sv ***
// Model of the external restart request lines
module irq_line_model (
    input  wire logic       sys_clk,
    input  wire logic [2:0] req,
    output logic            top_restart_irq, mid_restart_irq, low_restart_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge sys_clk) begin
        {top_restart_irq, mid_restart_irq, low_restart_irq} <= req;
    end
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the interrupt mask and status unit
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, srst = 1, mask_write_instr = 0, status_read_instr = 0;
    logic global_irq_enable_flag = 0, top_restart_irq, mid_restart_irq;
    logic low_restart_irq, tl = 0;
    logic [7:0] accumulator = 8'h00, status_read_value, a, r;
    logic [2:0] req = 3'h0, irq_mask, irq_pending, m = 3'h7;
    int err_total = 0, cmp_count = 0, seed = 32'he6a2bf72;
    initial forever #25 sys_clk = ~sys_clk;
    irq_line_model i_src (.sys_clk, .req, .top_restart_irq, .mid_restart_irq,
        .low_restart_irq);
    interrupt_mask_status_unit i_dut (.sys_clk, .srst, .mask_write_instr,
        .status_read_instr, .accumulator, .global_irq_enable_flag,
        .top_restart_irq, .mid_restart_irq, .low_restart_irq,
        .status_read_value, .irq_mask, .irq_pending);
    task automatic check(input string n, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        srst <= 0;
        @(posedge sys_clk);
        #1 check("reset mask", {5'h0, irq_mask}, 8'h07);
        check("reset status", status_read_value, 8'h07);
        for (int i = 0; i < 80; i++) begin
            @(posedge sys_clk);
            r = 8'($random(seed));
            if (r[2] && !req[2]) tl = 1;
            req <= r[2:0];
            global_irq_enable_flag <= r[7];
            repeat (6) @(posedge sys_clk);
            mask_write_instr <= 1;
            a = 8'($random(seed));
            accumulator <= a;
            @(posedge sys_clk);
            if (a[3]) m = a[2:0];
            mask_write_instr <= 0;
            status_read_instr <= 1;
            @(posedge sys_clk);
            status_read_instr <= 0;
            @(posedge sys_clk);
            #1 check("mask", {5'h0, irq_mask}, {5'h0, m});
            check("status", status_read_value,
                {1'b0, tl, req[1:0], r[7], m});
            if (a[4]) tl = 0;
            check("pending", {5'h0, irq_pending},
                {5'h0, tl, req[1:0]});
        end
        @(posedge sys_clk);
        srst <= 1;
        repeat (2) @(posedge sys_clk);
        srst <= 0;
        @(posedge sys_clk);
        #1 check("rst mask", {5'h0, irq_mask}, 8'h07);
        check("rst status", status_read_value, 8'h07);
        check("rst pending", {5'h0, irq_pending}, 8'h00);
        summarize;
    end
endmodule
